// ==== sim/alc_env_model.sv ====
// far-side model: ambient light sensor output and its supply rail
module alc_env_model (
  input  wire logic        pclk,
  input  wire logic        sensor_supply_en,
  input  wire logic [15:0] light_mv,
  input  wire logic [15:0] rail_mv,
  output logic      [15:0] sensor_mv,
  output logic      [15:0] supply_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] junk_reg;
  // an unpowered sensor floats, so show a value that changes every cycle
  initial junk_reg = 16'h5a5a;
  always @(posedge pclk) junk_reg <= ~junk_reg;
  assign sensor_mv = sensor_supply_en ? light_mv : junk_reg;
  assign supply_mv = sensor_supply_en ? rail_mv : 16'h0000;
endmodule : alc_env_model

// ==== sim/tb_top.sv ====
// self-checking bench for the automatic lamp controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FLT = 20;
  localparam int DEB = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic        run, aux, acc, auto_sw, m_tail, m_head, sup_en, tail, head, fault;
  logic [15:0] light, rail, sensor_mv, supply_mv;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int          n_fail, total_checks;
  alc_top #(.FAULT_CYCLES(FLT), .DEBOUNCE_CYCLES(DEB)) alc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ignition_run_feed(run), .ignition_aux_feed(aux), .accessory_feed(acc),
    .auto_switch(auto_sw), .manual_tail_req(m_tail), .manual_head_req(m_head),
    .sensor_mv(sensor_mv), .supply_mv(supply_mv), .sensor_supply_en(sup_en),
    .tail_relay(tail), .head_low_relay(head), .supply_fault(fault));
  alc_env_model alc_env_model_i (.pclk(pclk), .sensor_supply_en(sup_en), .light_mv(light),
    .rail_mv(rail), .sensor_mv(sensor_mv), .supply_mv(supply_mv));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  // each completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      e = exp_q.pop_front();
      chk("pslverr", 32'(pslverr), 32'(e[32]));
      if (!pwrite) chk("prdata", prdata, e[31:0]);
    end
  end
  // request is left up so a following call runs back to back
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic err);
    int i;
    exp_q.push_back({err, d});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      n_fail++;
      final_report();
    end
  endtask : apb
  task automatic apb_idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb_idle
  function automatic logic sig(int k);
    return k == 0 ? tail : (k == 1 ? head : fault);
  endfunction : sig
  // holds the old level for mn cycles, then must move within 12 more
  task automatic settle(string s, int k, logic v, int mn);
    int i;
    repeat (mn) @(posedge pclk);
    chk(s, 32'(sig(k)), 32'(!v));
    for (i = 0; i < 12 && sig(k) !== v; i++) @(posedge pclk);
    chk(s, 32'(sig(k)), 32'(v));
    if (sig(k) !== v) final_report();
  endtask : settle
  task automatic tick(int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  function automatic logic [31:0] xorshift(logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction : xorshift
  initial begin
    {psel, penable, pwrite, run, aux, acc, auto_sw, m_tail, m_head} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    light = 16'h0fa0;
    rail = 16'h1388;
    presetn = 1'b0;
    seed = 32'h1c;
    n_fail = 0;
    total_checks = 0;
    tick(3);
    presetn <= 1'b1;
    tick(1);
    apb(0, alc_pkg::CTRL_OFS, 32'h1, 0);
    apb(0, alc_pkg::STATUS_OFS, 32'h0, 0);
    apb(0, 12'h008, 32'h0, 1);
    apb(1, 12'h00c, 32'hffff_ffff, 1);
    apb_idle();
    $display("test registers done");
    acc <= 1'b1;
    tick(3);
    chk("supply_en", 32'(sup_en), 32'h1);
    acc <= 1'b0;
    run <= 1'b1;
    aux <= 1'b1;
    auto_sw <= 1'b1;
    light <= alc_pkg::HEAD_ON_MV;
    settle("tail dark", 0, 1, DEB - 2);
    chk("head dark", 32'(head), 32'h1);
    light <= alc_pkg::HEAD_OFF_MV;
    settle("head off", 1, 0, DEB - 2);
    chk("tail held", 32'(tail), 32'h1);
    light <= alc_pkg::TAIL_OFF_MV - 16'h1;
    tick(DEB + 6);
    chk("tail below off", 32'(tail), 32'h1);
    light <= alc_pkg::TAIL_OFF_MV;
    settle("tail off", 0, 0, DEB - 2);
    light <= alc_pkg::TAIL_ON_MV + 16'h1;
    tick(DEB + 6);
    chk("tail above on", 32'(tail), 32'h0);
    aux <= 1'b0;
    light <= alc_pkg::HEAD_ON_MV;
    settle("tail run only", 0, 1, DEB - 2);
    chk("head run only", 32'(head), 32'h0);
    $display("test auto done");
    auto_sw <= 1'b0;
    repeat (6) begin
      seed = xorshift(seed);
      m_tail <= seed[0];
      m_head <= seed[1];
      light <= seed[15:0];
      tick(3);
      chk("manual tail", 32'(tail), 32'(seed[0]));
      chk("manual head", 32'(head), 32'(seed[1]));
    end
    m_tail <= 1'b0;
    m_head <= 1'b1;
    auto_sw <= 1'b1;
    aux <= 1'b1;
    light <= 16'h0000;
    apb(1, alc_pkg::CTRL_OFS, 32'h0, 0);
    apb(0, alc_pkg::CTRL_OFS, 32'h0, 0);
    apb_idle();
    tick(DEB + 6);
    chk("auto off tail", 32'(tail), 32'h0);
    chk("auto off head", 32'(head), 32'h1);
    apb(1, alc_pkg::CTRL_OFS, 32'h1, 0);
    apb_idle();
    tick(3);
    chk("auto back", 32'(tail), 32'h1);
    $display("test manual done");
    light <= alc_pkg::TAIL_OFF_MV;
    settle("bright", 0, 0, DEB - 2);
    rail <= alc_pkg::SUPPLY_LO_MV - 16'h1;
    settle("fault low", 2, 1, FLT - 2);
    tick(2);
    chk("head forced", 32'(head), 32'h1);
    rail <= alc_pkg::SUPPLY_HI_MV;
    settle("fault clear", 2, 0, FLT - 2);
    tick(2);
    chk("head released", 32'(head), 32'h0);
    rail <= alc_pkg::SUPPLY_HI_MV + 16'h1;
    settle("fault high", 2, 1, FLT - 2);
    tick(2);
    apb(0, alc_pkg::STATUS_OFS, 32'h0000_000e, 0);
    apb_idle();
    $display("test fault done");
    final_report();
  end
endmodule : tb_top

// ==== src/alc_filter.sv ====
// persistence filter: output follows input only after it has differed long enough
module alc_filter #(
  parameter int unsigned CYCLES = alc_pkg::DEBOUNCE_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic raw,
  output logic      filt
);
  localparam logic [alc_pkg::CNT_W-1:0] LAST = alc_pkg::CNT_W'(CYCLES - 1);

  alc_pkg::alc_flt_t st_reg;
  alc_pkg::alc_flt_t st_next;

  always_comb begin
    st_next = st_reg;
    if (raw == st_reg.out) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt >= LAST) begin
      st_next.out = raw;
      st_next.cnt = '0;
    end else begin
      st_next.cnt = st_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign filt = st_reg.out;
endmodule : alc_filter

// ==== src/alc_pkg.sv ====
// shared constants and types for the automatic exterior lighting controller
package alc_pkg;
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned FAULT_TIME_MS = 300;
  localparam int unsigned DEBOUNCE_MS   = 100;
  localparam int unsigned FAULT_CYCLES  = FAULT_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W         = 25;

  // voltages are sampled in millivolts
  localparam int unsigned MV_W          = 16;
  localparam logic [15:0] TAIL_ON_MV    = 16'h06ea;
  localparam logic [15:0] TAIL_OFF_MV   = 16'h0d8e;
  localparam logic [15:0] HEAD_ON_MV    = 16'h0276;
  localparam logic [15:0] HEAD_OFF_MV   = 16'h03fc;
  localparam logic [15:0] SUPPLY_LO_MV  = 16'h0fa0;
  localparam logic [15:0] SUPPLY_HI_MV  = 16'h1770;

  localparam logic [11:0] CTRL_OFS      = 12'h000;
  localparam logic [11:0] STATUS_OFS    = 12'h004;
  localparam int unsigned CTRL_AUTO_BIT = 0;
  localparam logic        CTRL_AUTO_RST = 1'b1;

  typedef struct packed {
    logic             out;
    logic [CNT_W-1:0] cnt;
  } alc_flt_t;

  typedef struct packed {
    logic        auto_en;
    logic        supply_en;
    logic        oor;
    logic        tail_hyst;
    logic        head_hyst;
    logic        tail_relay;
    logic        head_relay;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } alc_state_t;
endpackage : alc_pkg

// ==== src/alc_top.sv ====
// automatic lamp control: sensor supply, fault filter, hysteresis, debounce, relays
//
// How it works
// RULE_01: run and aux feeds on with auto switch: tail and head follow the sensor.
// RULE_02: only run feed on with auto switch: tail follows sensor, head stays manual.
// RULE_03: sensor supply on while run or accessory feed is on; monitored when on.
// RULE_04: supply below 4 V or above 6 V counts as out of range.
// RULE_05: fault flag sets after 300 ms out of range, clears after 300 ms in range.
// RULE_06: while the fault flag is set, the head lamps stay on under automatic control.
// RULE_07: tail request on at 1.77 V or below, off at 3.47 V or above.
// RULE_08: head request on at 0.63 V or below, off at 1.02 V or above.
// RULE_09: on and off decisions pass a 100 ms debounce before the relays change.
// RULE_10: without auto switch or feeds, relays follow the manual lighting switch.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
module alc_top #(
  parameter int unsigned FAULT_CYCLES    = alc_pkg::FAULT_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = alc_pkg::DEBOUNCE_CYC
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      ignition_run_feed,
  input  wire logic                      ignition_aux_feed,
  input  wire logic                      accessory_feed,
  input  wire logic                      auto_switch,
  input  wire logic                      manual_tail_req,
  input  wire logic                      manual_head_req,
  input  wire logic [alc_pkg::MV_W-1:0]  sensor_mv,
  input  wire logic [alc_pkg::MV_W-1:0]  supply_mv,
  output logic                           sensor_supply_en,
  output logic                           tail_relay,
  output logic                           head_low_relay,
  output logic                           supply_fault
);
  alc_pkg::alc_state_t st_reg;
  alc_pkg::alc_state_t st_next;

  logic fault_in;
  logic fault_flt;
  logic tail_flt;
  logic head_flt;
  logic auto_tail;
  logic auto_head;
  logic setup_ph;
  logic access_ph;
  logic map_hit;
  logic [31:0] status_word;

  // while the supply is off nothing is measured, so the flag is frozen
  assign fault_in = st_reg.supply_en ? st_reg.oor : fault_flt;

  // RULE_05 fault persistence
  alc_filter #(.CYCLES(FAULT_CYCLES)) u_fault_flt (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (fault_in),
    .filt    (fault_flt)
  );

  // RULE_09 tail debounce
  alc_filter #(.CYCLES(DEBOUNCE_CYCLES)) u_tail_flt (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (st_reg.tail_hyst),
    .filt    (tail_flt)
  );

  // RULE_09 head debounce
  alc_filter #(.CYCLES(DEBOUNCE_CYCLES)) u_head_flt (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     (st_reg.head_hyst),
    .filt    (head_flt)
  );

  // RULE_01 head under auto
  assign auto_head = st_reg.auto_en & auto_switch & ignition_run_feed & ignition_aux_feed;
  // RULE_02 tail-only auto
  assign auto_tail = st_reg.auto_en & auto_switch & ignition_run_feed;

  assign setup_ph  = psel & ~penable;
  assign access_ph = psel & penable & st_reg.pready;
  assign map_hit   = (paddr == alc_pkg::CTRL_OFS) || (paddr == alc_pkg::STATUS_OFS);

  assign status_word = {24'h000000, head_flt, tail_flt, st_reg.head_hyst, st_reg.tail_hyst,
                        st_reg.supply_en, fault_flt, st_reg.head_relay, st_reg.tail_relay};

  always_comb begin
    st_next = st_reg;

    // RULE_03 sensor supply
    st_next.supply_en = ignition_run_feed | accessory_feed;

    // RULE_04 supply window
    st_next.oor = st_reg.supply_en &&
                  ((supply_mv < alc_pkg::SUPPLY_LO_MV) || (supply_mv > alc_pkg::SUPPLY_HI_MV));

    // hysteresis holds between thresholds; the reading only counts while powered
    if (st_reg.supply_en) begin
      // RULE_07 tail thresholds
      if (sensor_mv <= alc_pkg::TAIL_ON_MV) begin
        st_next.tail_hyst = 1'b1;
      end else if (sensor_mv >= alc_pkg::TAIL_OFF_MV) begin
        st_next.tail_hyst = 1'b0;
      end
      // RULE_08 head thresholds
      if (sensor_mv <= alc_pkg::HEAD_ON_MV) begin
        st_next.head_hyst = 1'b1;
      end else if (sensor_mv >= alc_pkg::HEAD_OFF_MV) begin
        st_next.head_hyst = 1'b0;
      end
    end

    // RULE_10 manual fallback
    st_next.tail_relay = auto_tail ? tail_flt : manual_tail_req;
    // RULE_06 fault forces head on
    st_next.head_relay = auto_head ? (head_flt | fault_flt) : manual_head_req;

    // apb: answer is prepared in the setup cycle so pready leaves a flop
    st_next.pready = setup_ph;
    if (setup_ph) begin
      st_next.pslverr = ~map_hit;
      st_next.prdata  = 32'h00000000;
      if (!pwrite && paddr == alc_pkg::CTRL_OFS) begin
        st_next.prdata[alc_pkg::CTRL_AUTO_BIT] = st_reg.auto_en;
      end else if (!pwrite && paddr == alc_pkg::STATUS_OFS) begin
        st_next.prdata = status_word;
      end
    end else if (access_ph) begin
      st_next.pslverr = 1'b0;
    end
    if (access_ph && pwrite && paddr == alc_pkg::CTRL_OFS) begin
      st_next.auto_en = pwdata[alc_pkg::CTRL_AUTO_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg         <= '0;
      st_reg.auto_en <= alc_pkg::CTRL_AUTO_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata           = st_reg.prdata;
  assign pready           = st_reg.pready;
  assign pslverr          = st_reg.pslverr;
  assign sensor_supply_en = st_reg.supply_en;
  assign tail_relay       = st_reg.tail_relay;
  assign head_low_relay   = st_reg.head_relay;
  assign supply_fault     = fault_flt;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  property p_head_auto;
    auto_head && !fault_flt |=> head_low_relay == $past(head_flt) && tail_relay == $past(tail_flt);
  endproperty
  a_head_auto: assert property (p_head_auto) // RULE_01
    else $error("head relay not following sensor");

  property p_tail_only;
    auto_tail && !ignition_aux_feed |=>
      tail_relay == $past(tail_flt) && head_low_relay == $past(manual_head_req);
  endproperty
  a_tail_only: assert property (p_tail_only) // RULE_02
    else $error("head relay not manual on run only");

  property p_supply;
    (ignition_run_feed || accessory_feed) |=> sensor_supply_en;
  endproperty
  a_supply: assert property (p_supply) else $error("sensor supply not switched on"); // RULE_03

  property p_window;
    sensor_supply_en && (supply_mv < 16'h0fa0 || supply_mv > 16'h1770) |=> st_reg.oor;
  endproperty
  a_window: assert property (p_window) else $error("out of range supply not detected"); // RULE_04

  property p_fault_persist;
    $changed(fault_flt) |-> $past(fault_in, 1) == fault_flt && $past(fault_in, 2) == fault_flt;
  endproperty
  a_fault_persist: assert property (p_fault_persist) // RULE_05
    else $error("fault flag changed early");

  property p_fault_head;
    auto_head && fault_flt |=> head_low_relay;
  endproperty
  a_fault_head: assert property (p_fault_head) // RULE_06
    else $error("head lamp off during fault");

  property p_tail_hyst;
    sensor_supply_en && sensor_mv <= 16'h06ea |=> st_reg.tail_hyst;
  endproperty
  a_tail_hyst: assert property (p_tail_hyst) // RULE_07
    else $error("tail request missing in dark");

  property p_head_hyst;
    sensor_supply_en && sensor_mv >= 16'h03fc |=> !st_reg.head_hyst;
  endproperty
  a_head_hyst: assert property (p_head_hyst) else $error("head request held in light"); // RULE_08

  property p_debounce;
    $changed(tail_flt) |-> $past(st_reg.tail_hyst, 1) == tail_flt
                        && $past(st_reg.tail_hyst, 2) == tail_flt;
  endproperty
  a_debounce: assert property (p_debounce) else $error("tail decision not debounced"); // RULE_09

  property p_manual;
    !auto_switch |=>
      tail_relay == $past(manual_tail_req) && head_low_relay == $past(manual_head_req);
  endproperty
  a_manual: assert property (p_manual) else $error("relays not under manual control"); // RULE_10

  // without the run feed neither lamp may stay under automatic control
  property p_feeds_off;
    !ignition_run_feed |=>
      tail_relay == $past(manual_tail_req) && head_low_relay == $past(manual_head_req);
  endproperty
  a_feeds_off: assert property (p_feeds_off) // RULE_10
    else $error("relays not manual with feeds off");
endmodule : alc_top
